// ==== hw/tpmc_pkg.sv ====
// Purpose: Constants for the transceiver power mode controller
// Assumes: 100 MHz clock, three drivers and three receivers
// Notes:   Register map is software-visible status and control
package tpmc_pkg;

    // ------------------------------------------------------------
    // Geometry and timing
    // ------------------------------------------------------------
    localparam int          NUM_LANES     = 3;
    localparam int          CLK_MHZ       = 100;
    localparam int          IDLE_SEC      = 30;
    localparam longint      IDLE_CYCLES   = longint'(IDLE_SEC) * 1000000
                                            * CLK_MHZ;
    localparam int          CNT_W         = 32;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  OFS_STATUS    = 4'h0;
    localparam logic [3:0]  OFS_IRQ_STAT  = 4'h4;
    localparam logic [3:0]  OFS_IRQ_MASK  = 4'h8;
    localparam logic [3:0]  OFS_CONTROL   = 4'hc;

    // Status fields
    localparam int          ST_ACTIVE     = 0;
    localparam int          ST_VALID      = 1;
    localparam int          ST_RECENT     = 2;
    localparam int          ST_PUMP_OK    = 3;

    // Interrupt event bits
    localparam int          EV_WAKE       = 0;
    localparam int          EV_SLEEP      = 1;
    localparam int          EV_VALID_CHG  = 2;
    localparam int          EV_W          = 3;

    // Control fields: bit 0 forces drivers on in any mode except force shutdown low
    localparam int          CT_TEST_ON    = 0;
    localparam logic [31:0] CONTROL_RST   = 32'h0000_0000;
    localparam logic [EV_W-1:0] MASK_RST  = 3'h0;

    // ------------------------------------------------------------
    // Driver state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TPMC_OFF  = 2'b00,
        TPMC_PUMP = 2'b01,
        TPMC_ON   = 2'b11
    } tpmc_state_t;

endpackage : tpmc_pkg

// ==== hw/tpmc_sync.sv ====
// Purpose: Two flip-flop synchroniser for a group of asynchronous inputs
// Assumes: Inputs come from pins outside the clock domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module tpmc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    always_comb begin
        meta_next = d_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign q_o = sync_reg;
endmodule : tpmc_sync

// ==== hw/tpmc_ctrl.sv ====
// Purpose: Driver enable and pump control for a serial line transceiver
// Assumes: Host drives force pins; line and level flags are asynchronous
// Notes:   Receivers are never gated; only drivers and pumps shut down
//
// Functional notes
// - Force shutdown low tristates all drivers
// - Both forces high keep drivers active
// - Auto mode: recent edge keeps drivers on
// - Auto mode: 30 s idle shuts drivers, pumps
// - Force-active from valid flag: idle and invalid off
// - Both from valid flag: follow valid level
// - Drivers wait for negative rail above 3V
// - Each driver inverts its logic input
// - Valid flag follows receiver level detector
// - Any edge wakes from automatic shutdown
`timescale 1ns/10ps
module tpmc_ctrl
    import tpmc_pkg::*;
#(
    parameter longint IDLE_LIMIT = IDLE_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Force controls from host
    input  wire logic                     force_active_in_i,
    input  wire logic                     force_shutdown_n_in_i,
    // Line side
    input  wire logic [NUM_LANES-1:0]     rx_line_i,
    input  wire logic [NUM_LANES-1:0]     tx_data_i,
    input  wire logic                     rx_level_ok_i,
    input  wire logic                     neg_rail_ok_i,
    output logic      [NUM_LANES-1:0]     tx_line_o,
    output logic      [NUM_LANES-1:0]     tx_line_oe_o,
    output logic      [NUM_LANES-1:0]     rx_data_o,
    output logic                          pump_en_o,
    output logic                          level_valid_o,
    // Register port
    input  wire logic [tpmc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [31:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [31:0]              rdata_o,
    // Interrupt
    output logic                          irq_o
);
    localparam int SW = 2 * NUM_LANES + 4;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    assign raw = {neg_rail_ok_i, rx_level_ok_i, force_shutdown_n_in_i,
                  force_active_in_i, tx_data_i, rx_line_i};

    tpmc_sync #(.W(SW)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (raw),
        .q_o   (syn)
    );

    logic [NUM_LANES-1:0] rx_s;
    logic [NUM_LANES-1:0] tx_s;
    logic                 fa_s;
    logic                 fs_n_s;
    logic                 valid_s;
    logic                 rail_s;
    assign rx_s    = syn[NUM_LANES-1:0];
    assign tx_s    = syn[2*NUM_LANES-1:NUM_LANES];
    assign fa_s    = syn[2*NUM_LANES];
    assign fs_n_s  = syn[2*NUM_LANES+1];
    assign valid_s = syn[2*NUM_LANES+2];
    assign rail_s  = syn[2*NUM_LANES+3];

    // ------------------------------------------------------------
    // Edge detection and inactivity timer
    // ------------------------------------------------------------
    logic [2*NUM_LANES-1:0] prev_reg;
    logic [2*NUM_LANES-1:0] prev_next;
    logic [CNT_W-1:0]       idle_reg;
    logic [CNT_W-1:0]       idle_next;
    logic                   recent_reg;
    logic                   recent_next;
    logic                   edge_seen;

    localparam logic [CNT_W-1:0] IDLE_MAX = IDLE_LIMIT[CNT_W-1:0];

    // Timer saturates so a long quiet line never wraps back to recent
    always_comb begin
        prev_next   = {tx_s, rx_s};
        edge_seen   = |(prev_next ^ prev_reg);
        idle_next   = idle_reg;
        recent_next = recent_reg;
        if (edge_seen) begin
            idle_next   = '0;
            recent_next = 1'b1;
        end else if (idle_reg >= IDLE_MAX - 1) begin
            recent_next = 1'b0;
        end else begin
            idle_next = idle_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg   <= '0;
            idle_reg   <= '0;
            recent_reg <= 1'b1;
        end else begin
            prev_reg   <= prev_next;
            idle_reg   <= idle_next;
            recent_reg <= recent_next;
        end
    end

    // ------------------------------------------------------------
    // Mode decision
    // ------------------------------------------------------------
    logic [31:0] control_reg;
    logic        want_on;

    // Tying a force pin to the valid flag shows up as the same level
    always_comb begin
        if (!fs_n_s) begin
            want_on = 1'b0;
        end else if (fa_s) begin
            want_on = 1'b1;
        end else begin
            want_on = recent_reg;
        end
        if (control_reg[CT_TEST_ON] && fs_n_s) begin
            want_on = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Driver state machine
    // ------------------------------------------------------------
    tpmc_state_t state_reg;
    tpmc_state_t state_next;

    function automatic logic drives(input tpmc_state_t s);
        return s == TPMC_ON;
    endfunction : drives

    function automatic logic pumps(input tpmc_state_t s);
        return s != TPMC_OFF;
    endfunction : pumps

    always_comb begin
        case (state_reg)
            TPMC_OFF:  state_next = want_on ? TPMC_PUMP : TPMC_OFF;
            TPMC_PUMP: begin
                if (!want_on) begin
                    state_next = TPMC_OFF;
                end else if (rail_s) begin
                    state_next = TPMC_ON;
                end else begin
                    state_next = TPMC_PUMP;
                end
            end
            TPMC_ON:   state_next = want_on ? TPMC_ON : TPMC_OFF;
            default:   state_next = TPMC_OFF;
        endcase
    end

    // Drivers only go from PUMP to ON once the synchronised rail reads good
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= TPMC_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Line outputs
    // ------------------------------------------------------------
    logic [NUM_LANES-1:0] tx_line_reg;
    logic [NUM_LANES-1:0] tx_oe_reg;
    logic [NUM_LANES-1:0] rx_out_reg;
    logic                 pump_reg;
    logic                 valid_reg;
    logic [NUM_LANES-1:0] tx_line_next;
    logic [NUM_LANES-1:0] tx_oe_next;
    logic [NUM_LANES-1:0] rx_out_next;
    logic                 pump_next;
    logic                 valid_next;

    // Each lane inverts its own data; the lanes share one enable
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        assign tx_line_next[g] = ~tx_s[g];
    end

    always_comb begin
        tx_oe_next  = drives(state_next) ? '1 : '0;
        pump_next   = pumps(state_next);
        rx_out_next = rx_s; // Receivers stay active in every mode
        valid_next  = valid_s;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_line_reg <= '0;
            tx_oe_reg   <= '0;
            rx_out_reg  <= '0;
            pump_reg    <= 1'b0;
            valid_reg   <= 1'b0;
        end else begin
            tx_line_reg <= tx_line_next;
            tx_oe_reg   <= tx_oe_next;
            rx_out_reg  <= rx_out_next;
            pump_reg    <= pump_next;
            valid_reg   <= valid_next;
        end
    end

    // ------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] stat_reg;
    logic [EV_W-1:0] stat_next;
    logic [EV_W-1:0] mask_reg;
    logic [EV_W-1:0] mask_next;
    logic [31:0]     control_next;
    logic [31:0]     rdata_reg;
    logic [31:0]     rdata_next;
    logic            irq_reg;
    logic            irq_next;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction : hit

    always_comb begin
        ev               = '0;
        ev[EV_WAKE]      = drives(state_next) && !drives(state_reg);
        ev[EV_SLEEP]     = !pumps(state_next) && pumps(state_reg);
        ev[EV_VALID_CHG] = valid_s ^ valid_reg;
        stat_next        = stat_reg;
        if (rd_i && hit(addr_i, OFS_IRQ_STAT)) begin
            stat_next = '0;
        end
        // Set wins over the read clear so no event is lost
        stat_next    = stat_next | ev;
        mask_next    = mask_reg;
        control_next = control_reg;
        if (wr_i && hit(addr_i, OFS_IRQ_MASK)) begin
            mask_next = wdata_i[EV_W-1:0];
        end
        if (wr_i && hit(addr_i, OFS_CONTROL)) begin
            control_next = {31'h0, wdata_i[CT_TEST_ON]};
        end
        rdata_next = '0;
        if (rd_i) begin
            case (addr_i)
                OFS_STATUS: begin
                    rdata_next[ST_ACTIVE]  = drives(state_reg);
                    rdata_next[ST_VALID]   = valid_reg;
                    rdata_next[ST_RECENT]  = recent_reg;
                    // Rail is read live so software can watch it settle
                    rdata_next[ST_PUMP_OK] = rail_s;
                end
                OFS_IRQ_STAT: rdata_next[EV_W-1:0] = stat_reg;
                OFS_IRQ_MASK: rdata_next[EV_W-1:0] = mask_reg;
                OFS_CONTROL:  rdata_next = control_reg;
                default:      rdata_next = '0;
            endcase
        end
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg    <= '0;
            mask_reg    <= MASK_RST;
            control_reg <= CONTROL_RST;
            rdata_reg   <= '0;
            irq_reg     <= 1'b0;
        end else begin
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            control_reg <= control_next;
            rdata_reg   <= rdata_next;
            irq_reg     <= irq_next;
        end
    end

    assign tx_line_o     = tx_line_reg;
    assign tx_line_oe_o  = tx_oe_reg;
    assign rx_data_o     = rx_out_reg;
    assign pump_en_o     = pump_reg;
    assign level_valid_o = valid_reg;
    assign rdata_o       = rdata_reg;
    assign irq_o         = irq_reg;
endmodule : tpmc_ctrl

// ==== tb/tpmc_ctrl_props.sv ====
// Purpose: Port assertions for the power mode controller
// Assumes: One clock, sync reset, two sync flops plus one register
// Notes:   Idle bound keeps slack for the sync delay
`timescale 1ns/10ps
module tpmc_ctrl_props
    import tpmc_pkg::*;
#(
    parameter longint IDLE_LIMIT = 50
) (
    // Clock, reset and pins
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       force_active_in_i,
    input wire logic       force_shutdown_n_in_i,
    input wire logic [2:0] rx_line_i,
    input wire logic [2:0] tx_data_i,
    input wire logic       rx_level_ok_i,
    input wire logic       neg_rail_ok_i,
    // Outputs watched
    input wire logic [2:0] tx_line_o,
    input wire logic [2:0] tx_line_oe_o,
    input wire logic [2:0] rx_data_o,
    input wire logic       pump_en_o,
    input wire logic       level_valid_o
);
    int warm;
    int idle_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Idle count restarts at the pin edge, so it runs ahead of the design by the sync delay
    always_ff @(posedge clk_i) begin
        warm <= rst_i ? 0 : (warm < 8 ? warm + 1 : warm);
        if (rst_i || force_active_in_i || !force_shutdown_n_in_i ||
            $changed(rx_line_i) || $changed(tx_data_i))
            idle_cnt <= 0;
        else if (idle_cnt < 100000)
            idle_cnt <= idle_cnt + 1;
    end
    property p_forced_off;
        (!force_shutdown_n_in_i) [*4] |-> tx_line_oe_o == 3'h0 && !pump_en_o;
    endproperty
    property p_forced_on;
        (force_active_in_i && force_shutdown_n_in_i) [*4] |-> pump_en_o;
    endproperty
    property p_idle_off;
        idle_cnt > IDLE_LIMIT + 8 |-> !pump_en_o && tx_line_oe_o == 3'h0;
    endproperty
    property p_wake;
        warm > 4 && ($changed(rx_line_i) || $changed(tx_data_i))
            |-> ##[0:6] (pump_en_o || !force_shutdown_n_in_i);
    endproperty
    property p_rail_first;
        $rose(tx_line_oe_o[0]) |-> $past(neg_rail_ok_i, 3);
    endproperty
    property p_invert;
        warm > 4 && tx_line_oe_o[0] |-> tx_line_o == ~$past(tx_data_i, 3);
    endproperty
    property p_valid;
        $stable(rx_level_ok_i) [*4] |=> level_valid_o == $past(rx_level_ok_i);
    endproperty
    property p_rx_pass;
        warm > 4 |-> rx_data_o == $past(rx_line_i, 3);
    endproperty
    a_forced_off: assert property (p_forced_off)
        else $error("drivers on while forced off");
    a_forced_on: assert property (p_forced_on)
        else $error("pump off while forced on");
    a_idle_off: assert property (p_idle_off)
        else $error("drivers on after idle time");
    a_wake: assert property (p_wake)
        else $error("no wake after edge");
    a_rail_first: assert property (p_rail_first)
        else $error("drivers on before rail");
    a_invert: assert property (p_invert)
        else $error("driver output not inverted");
    a_valid: assert property (p_valid)
        else $error("valid flag wrong");
    a_rx_pass: assert property (p_rx_pass)
        else $error("receiver output wrong");
    c_sleep: cover property ($fell(pump_en_o));
    c_wake: cover property ($rose(tx_line_oe_o[0]));
    c_valid: cover property ($rose(level_valid_o));
endmodule : tpmc_ctrl_props

bind tpmc_ctrl tpmc_ctrl_props #(.IDLE_LIMIT(IDLE_LIMIT)) props_inst (
    .clk_i(clk_i), .rst_i(rst_i), .force_active_in_i(force_active_in_i),
    .force_shutdown_n_in_i(force_shutdown_n_in_i), .rx_line_i(rx_line_i),
    .tx_data_i(tx_data_i), .rx_level_ok_i(rx_level_ok_i),
    .neg_rail_ok_i(neg_rail_ok_i), .tx_line_o(tx_line_o),
    .tx_line_oe_o(tx_line_oe_o), .rx_data_o(rx_data_o),
    .pump_en_o(pump_en_o), .level_valid_o(level_valid_o));

// ==== tb/tpmc_host_model.sv ====
// Purpose: Host force pins and a slow negative pump rail
// Assumes: Mode 0 off, 1 on, 2 auto, 3 and 4 tied to the valid flag
// Notes:   Rail needs several cycles of pumping before it is good
`timescale 1ns/10ps
module tpmc_host_model #(
    parameter int RAIL_DLY = 5
) (
    input  wire logic       clk_i,
    input  wire logic [2:0] mode_i,
    input  wire logic       level_i,
    input  wire logic       pump_en_i,
    output logic            force_active_o = 1'b0,
    output logic            force_shutdown_n_o = 1'b0,
    output logic            neg_rail_ok_o = 1'b0
);
    int pump_cnt = 0;
    always @(posedge clk_i) begin
        case (mode_i)
            3'd0: {force_active_o, force_shutdown_n_o} <= 2'b00;
            3'd1: {force_active_o, force_shutdown_n_o} <= 2'b11;
            3'd2: {force_active_o, force_shutdown_n_o} <= 2'b01;
            3'd3: {force_active_o, force_shutdown_n_o} <= {level_i, 1'b1};
            default: {force_active_o, force_shutdown_n_o} <= {2{level_i}};
        endcase
        pump_cnt <= pump_en_i ? pump_cnt + int'(pump_cnt < RAIL_DLY) : 0;
        neg_rail_ok_o <= pump_en_i && pump_cnt >= RAIL_DLY;
    end
endmodule : tpmc_host_model

// ==== tb/tpmc_ctrl_tb.sv ====
// Purpose: Self-checking bench for the power mode controller
// Assumes: Host model drives force pins and pump rail
// Notes:   Idle limit shortened so the run stays brief
`timescale 1ns/10ps
module tpmc_ctrl_tb;
    import tpmc_pkg::*;
    localparam longint IDLE = 50;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        fa, fs_n, rail;
    logic        lvl = 1'b0;
    logic [2:0]  mode = 3'd0;
    logic [2:0]  rx_line_i = 3'h0;
    logic [2:0]  tx_data_i = 3'h0;
    logic [2:0]  tx_line_o, tx_line_oe_o, rx_data_o;
    logic        pump_en_o, level_valid_o, irq_o;
    logic [3:0]  addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [31:0] rdata_o;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    int          mismatches = 0;
    int          check_count = 0;
    int          seed = 91978;
    logic [2:0]  rq[$];
    logic [2:0]  tq[$];
    always #5 clk_i = ~clk_i;
    tpmc_host_model host_inst (.clk_i(clk_i), .mode_i(mode), .level_i(lvl),
        .pump_en_i(pump_en_o), .force_active_o(fa),
        .force_shutdown_n_o(fs_n), .neg_rail_ok_o(rail));
    tpmc_ctrl #(.IDLE_LIMIT(IDLE)) tpmc_ctrl_inst (.clk_i(clk_i),
        .rst_i(rst_i), .force_active_in_i(fa), .force_shutdown_n_in_i(fs_n),
        .rx_line_i(rx_line_i), .tx_data_i(tx_data_i), .rx_level_ok_i(lvl),
        .neg_rail_ok_i(rail), .tx_line_o(tx_line_o),
        .tx_line_oe_o(tx_line_oe_o), .rx_data_o(rx_data_o),
        .pump_en_o(pump_en_o), .level_valid_o(level_valid_o),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .irq_o(irq_o));
    task automatic end_of_test();
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk(rdata_o, e);
    endtask : rd
    // Expected driver state from pins, valid level and recent edge
    function automatic logic exp_on(input int m, input logic l, input logic r);
        case (m)
            0: return 1'b0;
            1: return 1'b1;
            2: return r;
            3: return l | r;
            default: return l;
        endcase
    endfunction : exp_on
    task automatic step(input int m, input logic l, input logic r);
        int i;
        logic e;
        e = exp_on(m, l, r);
        @(posedge clk_i);
        mode <= 3'(m);
        lvl  <= l;
        if (r)
            tx_data_i <= ~tx_data_i;
        // Let the pins pass the host stage and both sync flops first; with no edge, also wait out the idle limit
        repeat (r ? 6 : IDLE + 12) @(posedge clk_i);
        #1;
        for (i = 0; i < 40 && {pump_en_o, tx_line_oe_o} !== {4{e}}; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk({28'h0, pump_en_o, tx_line_oe_o}, {28'h0, {4{e}}});
        if (i == 40) begin
            mismatches++;
            end_of_test();
        end
    endtask : step
    initial begin
        logic [31:0] v;
        int k;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_IRQ_MASK, 32'h0);
        rd(OFS_CONTROL, 32'h0);
        wr(4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0);
        step(0, 1'b0, 1'b1);
        step(1, 1'b0, 1'b1);
        step(2, 1'b0, 1'b1);
        step(2, 1'b0, 1'b0);
        chk({31'h0, irq_o}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h7);
        rd(OFS_IRQ_MASK, 32'h7);
        chk({31'h0, irq_o}, 32'h1);
        rd(OFS_IRQ_STAT, 32'h3);
        @(posedge clk_i);
        #1 chk({31'h0, irq_o}, 32'h0);
        step(2, 1'b0, 1'b1);
        step(3, 1'b1, 1'b0);
        step(3, 1'b0, 1'b0);
        step(3, 1'b0, 1'b1);
        step(4, 1'b1, 1'b0);
        chk({31'h0, level_valid_o}, 32'h1);
        rd(OFS_STATUS, 32'hb);
        step(4, 1'b0, 1'b1);
        step(1, 1'b0, 1'b1);
        wr(OFS_CONTROL, 32'h1);
        rd(OFS_CONTROL, 32'h1);
        step(0, 1'b0, 1'b1);
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            v = $random(seed);
            rx_line_i <= v[2:0];
            tx_data_i <= v[5:3];
            rq.push_back(v[2:0]);
            tq.push_back(v[5:3]);
            #1;
            if (k > 2) begin
                chk({29'h0, rx_data_o}, {29'h0, rq[k-3]});
                chk({29'h0, tx_line_o}, {29'h0, ~tq[k-3]});
            end
        end
        end_of_test();
    end
endmodule : tpmc_ctrl_tb
